//--- inc/latch_status_pkg.sv
package latch_status_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_COMMAND    = 8'h00;
   localparam logic [7:0] ADDR_SUBSTATUS  = 8'h04;
   localparam logic [7:0] ADDR_EXT_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CLEAR      = 8'h0C;
   localparam logic [7:0] ADDR_SEQ_LEN    = 8'h10;
   localparam logic [7:0] ADDR_SELECT     = 8'h14;
   // command register fields
   localparam int SEL_LSB  = 0;
   localparam int CODE_LSB = 8;
   // subcommand codes
   localparam logic [3:0] CMD_MONITOR  = 4'h1;
   localparam logic [3:0] CMD_MODE_ON  = 4'h2;
   localparam logic [3:0] CMD_MODE_OFF = 4'h3;
   localparam logic [3:0] CMD_LATCH    = 4'h4;
   // latch source codes
   localparam logic [1:0] SRC_INDEX = 2'h0;
   localparam logic [1:0] SRC_EXTERNAL_LATCH_INPUT_ONE  = 2'h1;
   localparam logic [1:0] SRC_EXTERNAL_LATCH_INPUT_TWO  = 2'h2;
   localparam logic [1:0] SRC_EXTERNAL_LATCH_INPUT_THREE  = 2'h3;
   // substatus bit positions
   localparam int SUB_ALARM_BIT = 0;
   localparam int SUB_WARN_BIT  = 1;
   localparam int SUB_READY_BIT = 2;
   // extension status field positions
   localparam int EXT_CNT_LSB = 0;
   localparam int EXT_SEQ_LSB = 8;
   // reset values
   localparam logic [3:0] SEQ_LEN_RESET = 4'h1;
   // subcommand busy time
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUSY_TIME_NS  = 50;
   localparam int BUSY_CYCLES   = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- verilog/rise_detect.sv
`timescale 1ns/1ps
module rise_detect
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic level,
   output logic      rise
);
   typedef struct packed
   {
      logic prev;
      logic rise;
   } edge_state_type;

   edge_state_type st_ff;
   edge_state_type nxt_st;

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.prev = level;
      nxt_st.rise = level & ~st_ff.prev;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign rise = st_ff.rise;

   a_rise_single: assert property (@(posedge clk) disable iff (rst) rise |=> !rise)
      else $error("rise lasted more than one cycle");
endmodule

//--- verilog/busy_timer.sv
`timescale 1ns/1ps
module busy_timer
#(
   parameter int CYCLES = 5
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic start,
   output logic      busy
);
   localparam int W = $clog2(CYCLES + 1);

   // refuse a busy time shorter than one cycle
   if (CYCLES < 1)
   begin : g_bad_cycles
      $error("busy_timer needs at least one cycle");
   end

   typedef struct packed
   {
      logic [W-1:0] count;
      logic         busy;
   } timer_state_type;

   timer_state_type st_ff;
   timer_state_type nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      if (start)
      begin
         nxt_st.count = W'(CYCLES);
      end
      else if (st_ff.count != '0)
      begin
         nxt_st.count = st_ff.count - 1'b1;
      end
      nxt_st.busy = (nxt_st.count != '0);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign busy = st_ff.busy;

   a_busy_length: assert property (@(posedge clk) disable iff (rst)
      start |=> busy [*5] ##1 (!busy || $past(start)))
      else $error("busy time not held for its full length");
endmodule

//--- verilog/latch_status.sv
`timescale 1ns/1ps
// Functional notes
// - The latch source field is eight bits, only its two low bits select, and the upper six must be zero.
// - Selector 0 picks the encoder index pulse, 1 external input one, 2 external input two, 3 external input three.
// - The substatus byte carries the subcommand alarm in bit 0 and warning in bit 1, bits 7 to 3 reserved.
// - Substatus bit 2 is 1 when a new subcommand can be taken and 0 while busy.
// - Extension status is filled only after an accepted subcommand: monitor, capture mode on, capture mode off or latch.
// - In continuous capture an eight-bit counter in the low byte counts completed latch sequences.
// - In single latching the completion counter stays zero.
// - In continuous capture bits 11 to 8 give the index of the sequence just completed, zero otherwise.
// - Each external latch source is a digital input read as on when high and off when low.
module latch_status
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        encoder_index_pulse,
   input  wire logic        external_latch_input_one,
   input  wire logic        external_latch_input_two,
   input  wire logic        external_latch_input_three,
   output logic             latch_capture_pulse,
   output logic      [7:0]  substatus_byte,
   output logic      [15:0] extension_status_word
);
   typedef struct packed
   {
      logic        waitrequest;
      logic [31:0] readdata;
      logic [7:0]  latch_source_select;
      logic        continuous_mode;
      logic        monitor_enable;
      logic        armed;
      logic        subcommand_alarm_flag;
      logic        subcommand_warning_flag;
      logic [7:0]  latch_sequence_done_counter;
      logic [3:0]  latch_sequence_index;
      logic [3:0]  sequence_length;
      logic        capture_pulse;
      logic [7:0]  substatus;
      logic [15:0] ext_status;
   } main_state_type;

   main_state_type st_ff;
   main_state_type nxt_st;

   logic [3:0] source_level;
   logic [3:0] source_rise;
   logic       busy;
   logic       take_write;
   logic       take_read;
   logic       cmd_write;
   logic       cmd_accept;
   logic [3:0] cmd_code;
   logic [7:0] cmd_select;
   logic       cmd_valid_code;
   logic       cmd_select_ok;
   logic       trigger_hit;

   // latch sources, each high means on
   assign source_level = {external_latch_input_three, external_latch_input_two,
                          external_latch_input_one, encoder_index_pulse};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_src
         rise_detect u_rise
         (
            .clk   (clk),
            .rst   (rst),
            .level (source_level[gi]),
            .rise  (source_rise[gi])
         );
      end
   endgenerate

   busy_timer #(.CYCLES(latch_status_pkg::BUSY_CYCLES)) u_busy
   (
      .clk   (clk),
      .rst   (rst),
      .start (cmd_accept),
      .busy  (busy)
   );

   // bus handshake: one wait cycle, then the access completes
   assign take_write = avs_write & ~st_ff.waitrequest;
   assign take_read  = avs_read & st_ff.waitrequest;
   assign cmd_write  = take_write & (avs_address == latch_status_pkg::ADDR_COMMAND) & avs_byteenable[1];
   assign cmd_code   = avs_writedata[latch_status_pkg::CODE_LSB +: 4];
   assign cmd_select = avs_byteenable[0] ? avs_writedata[latch_status_pkg::SEL_LSB +: 8]
                                         : st_ff.latch_source_select;
   assign cmd_valid_code = (cmd_code == latch_status_pkg::CMD_MONITOR) |
                           (cmd_code == latch_status_pkg::CMD_MODE_ON) |
                           (cmd_code == latch_status_pkg::CMD_MODE_OFF) |
                           (cmd_code == latch_status_pkg::CMD_LATCH);
   assign cmd_select_ok = (cmd_select[7:2] == 6'h00);
   assign cmd_accept = cmd_write & ~busy & cmd_valid_code & cmd_select_ok;

   // selector decode onto the armed trigger
   assign trigger_hit = st_ff.armed & source_rise[st_ff.latch_source_select[1:0]];

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.capture_pulse = 1'b0;
      nxt_st.waitrequest = ~((avs_read | avs_write) & st_ff.waitrequest);

      // register reads
      if (take_read)
      begin
         case (avs_address)
            latch_status_pkg::ADDR_SUBSTATUS:  nxt_st.readdata = {24'h000000, st_ff.substatus};
            latch_status_pkg::ADDR_EXT_STATUS: nxt_st.readdata = {16'h0000, st_ff.ext_status};
            latch_status_pkg::ADDR_SEQ_LEN:    nxt_st.readdata = {28'h0000000, st_ff.sequence_length};
            latch_status_pkg::ADDR_SELECT:     nxt_st.readdata = {24'h000000, st_ff.latch_source_select};
            default:                           nxt_st.readdata = 32'h00000000;
         endcase
      end

      // flag clears first, so that a set in the same cycle wins
      if (take_write & (avs_address == latch_status_pkg::ADDR_CLEAR) & avs_byteenable[0])
      begin
         if (avs_writedata[latch_status_pkg::SUB_ALARM_BIT])
         begin
            nxt_st.subcommand_alarm_flag = 1'b0;
         end
         if (avs_writedata[latch_status_pkg::SUB_WARN_BIT])
         begin
            nxt_st.subcommand_warning_flag = 1'b0;
         end
      end

      if (take_write & (avs_address == latch_status_pkg::ADDR_SEQ_LEN) & avs_byteenable[0])
      begin
         nxt_st.sequence_length = (avs_writedata[3:0] == 4'h0) ? 4'h1 : avs_writedata[3:0];
      end

      // captures
      if (trigger_hit)
      begin
         nxt_st.capture_pulse = 1'b1;
         if (st_ff.continuous_mode)
         begin
            nxt_st.latch_sequence_done_counter = st_ff.latch_sequence_done_counter + 8'h01;
            nxt_st.latch_sequence_index = (st_ff.latch_sequence_index >= st_ff.sequence_length)
                                          ? 4'h1 : st_ff.latch_sequence_index + 4'h1;
         end
         else
         begin
            nxt_st.armed = 1'b0;
         end
      end

      // subcommands
      if (cmd_write & busy)
      begin
         nxt_st.subcommand_warning_flag = 1'b1;
      end
      else if (cmd_write & ~(cmd_valid_code & cmd_select_ok))
      begin
         nxt_st.subcommand_alarm_flag = 1'b1;
      end
      if (cmd_accept)
      begin
         nxt_st.monitor_enable = 1'b1;
         case (cmd_code)
            latch_status_pkg::CMD_MODE_ON:
            begin
               nxt_st.latch_source_select = cmd_select;
               nxt_st.continuous_mode = 1'b1;
               nxt_st.armed = 1'b1;
               nxt_st.latch_sequence_done_counter = 8'h00;
               nxt_st.latch_sequence_index = 4'h0;
            end
            latch_status_pkg::CMD_MODE_OFF:
            begin
               nxt_st.continuous_mode = 1'b0;
               nxt_st.armed = 1'b0;
            end
            latch_status_pkg::CMD_LATCH:
            begin
               nxt_st.latch_source_select = cmd_select;
               nxt_st.continuous_mode = 1'b0;
               nxt_st.armed = 1'b1;
            end
            default:
            begin
               nxt_st.monitor_enable = 1'b1;
            end
         endcase
      end

      // single latching keeps the sequence fields at zero
      if (!nxt_st.continuous_mode)
      begin
         nxt_st.latch_sequence_done_counter = 8'h00;
         nxt_st.latch_sequence_index = 4'h0;
      end

      // status images, reserved bits zero
      nxt_st.substatus = 8'h00;
      nxt_st.substatus[latch_status_pkg::SUB_ALARM_BIT] = nxt_st.subcommand_alarm_flag;
      nxt_st.substatus[latch_status_pkg::SUB_WARN_BIT] = nxt_st.subcommand_warning_flag;
      nxt_st.substatus[latch_status_pkg::SUB_READY_BIT] = ~busy & ~cmd_accept;
      nxt_st.ext_status = 16'h0000;
      if (nxt_st.monitor_enable)
      begin
         nxt_st.ext_status[latch_status_pkg::EXT_CNT_LSB +: 8] = nxt_st.latch_sequence_done_counter;
         nxt_st.ext_status[latch_status_pkg::EXT_SEQ_LSB +: 4] = nxt_st.latch_sequence_index;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '0;
         st_ff.waitrequest <= 1'b1;
         st_ff.sequence_length <= latch_status_pkg::SEQ_LEN_RESET;
         st_ff.substatus[latch_status_pkg::SUB_READY_BIT] <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata          = st_ff.readdata;
   assign avs_waitrequest       = st_ff.waitrequest;
   assign latch_capture_pulse   = st_ff.capture_pulse;
   assign substatus_byte        = st_ff.substatus;
   assign extension_status_word = st_ff.ext_status;

   a_select_upper_zero: assert property (@(posedge clk) disable iff (rst)
      st_ff.latch_source_select[7:2] == 6'h00)
      else $error("latch source field holds nonzero upper bits");

   a_source_decode: assert property (@(posedge clk) disable iff (rst)
      (st_ff.armed && source_rise[st_ff.latch_source_select[1:0]]) |=> latch_capture_pulse)
      else $error("selected source edge gave no capture");

   a_source_wrong: assert property (@(posedge clk) disable iff (rst)
      latch_capture_pulse |-> $past(source_rise[st_ff.latch_source_select[1:0]]))
      else $error("capture without an edge on the selected input");

   a_bad_cmd_alarm: assert property (@(posedge clk) disable iff (rst)
      (cmd_write && !busy && !cmd_select_ok) |=> substatus_byte[0])
      else $error("bad subcommand raised no alarm");

   a_ready_tracks_busy: assert property (@(posedge clk) disable iff (rst)
      cmd_accept |=> !substatus_byte[2] [*6] ##1 substatus_byte[2])
      else $error("ready bit does not follow the busy time");

   a_ext_gated: assert property (@(posedge clk) disable iff (rst)
      !st_ff.monitor_enable |-> extension_status_word == 16'h0000)
      else $error("extension status filled before monitoring enabled");

   a_count_step: assert property (@(posedge clk) disable iff (rst)
      (trigger_hit && st_ff.continuous_mode && !cmd_accept)
      |=> st_ff.latch_sequence_done_counter == $past(st_ff.latch_sequence_done_counter) + 8'h01)
      else $error("completion counter did not step");

   a_single_zero: assert property (@(posedge clk) disable iff (rst)
      !st_ff.continuous_mode |-> st_ff.latch_sequence_done_counter == 8'h00)
      else $error("counter nonzero in single latching");

   a_seq_zero: assert property (@(posedge clk) disable iff (rst)
      !st_ff.continuous_mode |-> st_ff.latch_sequence_index == 4'h0)
      else $error("sequence index nonzero in single latching");

   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      substatus_byte[7:3] == 5'h00 && extension_status_word[15:12] == 4'h0)
      else $error("reserved status bits not zero");

   c_continuous_wrap: cover property (@(posedge clk) disable iff (rst)
      trigger_hit && st_ff.continuous_mode && st_ff.latch_sequence_index == st_ff.sequence_length);
   c_single_capture: cover property (@(posedge clk) disable iff (rst)
      trigger_hit && !st_ff.continuous_mode);
   c_busy_warning: cover property (@(posedge clk) disable iff (rst) cmd_write && busy);
endmodule

//--- bench/host_model.sv
`timescale 1ns/1ps
module host_model
(
   input  wire logic        clk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output logic      [7:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable
);
   logic [31:0] rdata;

   initial
   begin
      avs_address    = 8'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'hF;
      rdata          = 32'h0;
   end

   // one bus cycle, held until waitrequest is sampled low
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         avs_address   <= a;
         avs_writedata <= d;
         avs_read      <= !wr;
         avs_write     <= wr;
         do
         begin
            @(posedge clk);
         end
         while (avs_waitrequest !== 1'b0);
         rdata = avs_readdata;
         avs_read  <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask

   // subcommand write, select byte passed whole
   task automatic cmd(input logic [3:0] code, input logic [7:0] sel);
      xfer(1'b1, latch_status_pkg::ADDR_COMMAND, {20'h0, code, sel});
   endtask
endmodule

//--- bench/latch_status_tb.sv
`timescale 1ns/1ps
module latch_status_tb;
   logic        clk;
   logic        rst;
   logic [3:0]  src;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        latch_capture_pulse;
   logic [7:0]  substatus_byte;
   logic [15:0] extension_status_word;
   int          error_cnt;
   int          checks;
   int          seed;
   int          caps;
   int          n;
   int          cnt;
   int          len;
   logic [1:0]  s;

   always #5 clk = ~clk;

   always @(posedge clk)
      if (latch_capture_pulse === 1'b1)
         caps <= caps + 1;

   host_model host (.clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write,
                    .avs_writedata, .avs_byteenable);

   latch_status dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
                     .avs_readdata, .avs_waitrequest, .encoder_index_pulse(src[0]),
                     .external_latch_input_one(src[1]), .external_latch_input_two(src[2]),
                     .external_latch_input_three(src[3]), .latch_capture_pulse, .substatus_byte,
                     .extension_status_word);

   task automatic bump(input bit bad, input string m);
      checks++;
      if (bad)
      begin
         error_cnt++;
         $display("Error at %0t: %s mismatch", $time, m);
      end
   endtask

   task automatic chk_sub(input logic [7:0] g, input logic [7:0] e);
      bump(g !== e, "substatus");
   endtask

   task automatic chk_ext(input logic [15:0] g, input logic [15:0] e);
      bump(g !== e, "extension status");
   endtask

   task automatic chk_cap(input int g, input int e);
      bump(g != e, "capture count");
   endtask

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      bump(g !== e, "register read");
   endtask

   function automatic logic [15:0] exp_ext(input int c, input int l);
      logic [3:0] idx;
      idx = (c == 0) ? 4'h0 : 4'((c - 1) % l + 1);
      return {4'h0, idx, 8'(c)};
   endfunction

   task automatic pulse(input int i);
      @(posedge clk);
      src[i] <= 1'b1;
      repeat (2) @(posedge clk);
      src[i] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic wait_ready();
      int k;
      begin
         k = 0;
         #1;
         while (substatus_byte[2] !== 1'b1 && k < latch_status_pkg::BUSY_CYCLES + 4)
         begin
            @(posedge clk);
            #1;
            k++;
         end
      end
   endtask

   task automatic cmd_ok(input logic [3:0] code, input logic [7:0] sel);
      host.cmd(code, sel);
      @(posedge clk);
      #1;
      chk_sub(substatus_byte & 8'h04, 8'h00);
      wait_ready();
      chk_sub(substatus_byte, 8'h04);
   endtask

   task automatic end_sim();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      src = 4'h0;
      error_cnt = 0;
      checks = 0;
      seed = 65;
      caps = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk_sub(substatus_byte, 8'h04);
      chk_ext(extension_status_word, 16'h0000);
      host.cmd(latch_status_pkg::CMD_LATCH, 8'($random(seed)) | 8'h04);
      repeat (2) @(posedge clk);
      #1;
      chk_sub(substatus_byte, 8'h05);
      chk_ext(extension_status_word, 16'h0000);
      host.xfer(1'b1, latch_status_pkg::ADDR_CLEAR, 32'h3);
      host.cmd(latch_status_pkg::CMD_MONITOR, 8'h00);
      host.cmd(latch_status_pkg::CMD_MONITOR, 8'h00);
      wait_ready();
      chk_sub(substatus_byte, 8'h06);
      host.xfer(1'b1, latch_status_pkg::ADDR_CLEAR, 32'h3);
      for (int i = 0; i < 4; i++)
      begin
         cmd_ok(latch_status_pkg::CMD_LATCH, 8'(i));
         n = caps;
         pulse((i + 1) % 4);
         chk_cap(caps - n, 0);
         pulse(i);
         chk_cap(caps - n, 1);
         pulse(i);
         chk_cap(caps - n, 1);
         chk_ext(extension_status_word, 16'h0000);
      end
      len = 2 + ($random(seed) & 3);
      host.xfer(1'b1, latch_status_pkg::ADDR_SEQ_LEN, 32'(len));
      s = 2'($random(seed));
      cmd_ok(latch_status_pkg::CMD_MODE_ON, {6'h0, s});
      host.xfer(1'b0, latch_status_pkg::ADDR_SELECT, 32'h0);
      chk_reg(host.rdata, {30'h0, s});
      host.xfer(1'b0, latch_status_pkg::ADDR_SEQ_LEN, 32'h0);
      chk_reg(host.rdata, 32'(len));
      n = caps;
      cnt = 4 + ($random(seed) & 7);
      for (int k = 0; k < cnt; k++)
         pulse(int'(s));
      chk_cap(caps - n, cnt);
      chk_ext(extension_status_word, exp_ext(cnt, len));
      host.xfer(1'b0, latch_status_pkg::ADDR_EXT_STATUS, 32'h0);
      chk_ext(host.rdata[15:0], exp_ext(cnt, len));
      chk_ext(host.rdata[31:16], 16'h0000);
      cmd_ok(latch_status_pkg::CMD_MODE_OFF, {6'h0, s});
      cmd_ok(latch_status_pkg::CMD_LATCH, {6'h0, s});
      pulse(int'(s));
      chk_ext(extension_status_word, 16'h0000);
      host.xfer(1'b0, 8'h3C, 32'h0);
      chk_ext(host.rdata[15:0], 16'h0000);
      end_sim();
   end
endmodule
